// *** rtl/fsg_map.svh ***
// Constants for the floating-point and SIMD access gating block.
// Assumes inclusion by the package, the gating module, the checker and the bench.
`ifndef FSG_MAP_SVH
`define FSG_MAP_SVH

// ---------------------------------------------------------------------------
// Register data and fields
// ---------------------------------------------------------------------------
`define FSG_DW 32
`define FSG_EN_BIT 30
`define FSG_DEX_BIT 29
`define FSG_CPA_LO 20
`define FSG_CPA_HI 23
`define FSG_SIMD_DISABLE_BIT_BIT 31
`define FSG_NS_COPROC_TEN_BIT 10
`define FSG_NS_COPROC_ELEVEN_BIT 11
`define FSG_NS_SIMD_LO 14
`define FSG_NS_SIMD_HI 15
`define FSG_ZERO_WORD 32'h0000_0000
`define FSG_FP_STATUS_CONTROL_REG_RST 32'h0000_0000
`define FSG_FP_EXCEPTION_CONTROL_REG_RST 32'h0000_0000
`define FSG_MFA_VAL 32'h1011_0222
`define FSG_MFB_VAL 32'h1111_1111
// Identity word: value is arbitrary
`define FSG_SYSID_VAL 32'h0000_0001

// ---------------------------------------------------------------------------
// System register selectors on the move port
// ---------------------------------------------------------------------------
`define FSG_SEL_SYSID 3'h0
`define FSG_SEL_FP_STATUS_CONTROL_REG 3'h1
`define FSG_SEL_MFB 3'h6
`define FSG_SEL_MFA 3'h7
`define FSG_SEL_FP_EXCEPTION_CONTROL_REG 3'h3

// ---------------------------------------------------------------------------
// Access field encodings and privilege codes
// ---------------------------------------------------------------------------
`define FSG_CPA_NONE 2'h0
`define FSG_CPA_PRIV 2'h1
`define FSG_CPA_FULL 2'h3
`define FSG_PL_USER 2'h0
`define FSG_PL_HYP 2'h2

`endif

// *** rtl/fsg_pkg.sv ***
// Types for the floating-point and SIMD access gating block.
// Assumes fsg_map.svh is on the include path.
`include "fsg_map.svh"

package fsg_pkg;

	// Kind of instruction offered for issue
	typedef enum logic [2:0] {
		FSG_OP_SCALAR = 3'b000,
		FSG_OP_SIMD = 3'b001,
		FSG_OP_VECTOR = 3'b010,
		FSG_OP_MOVE_TO = 3'b011,
		FSG_OP_MOVE_FROM = 3'b100
	} fsg_op_e;

	// Outcome state of the instruction issued in the previous cycle, idle if none was issued
	typedef enum logic [1:0] {
		FSG_ST_IDLE = 2'b00,
		FSG_ST_EXEC = 2'b01,
		FSG_ST_UNDEF = 2'b10
	} fsg_state_e;

	typedef logic [`FSG_DW-1:0] fsg_word_t;

endpackage : fsg_pkg

// *** rtl/fsg_gate.sv ***
// Access gating for the floating-point and SIMD unit: decides per issued
// instruction whether it executes or raises an undefined instruction trap,
// and holds the unit's system registers reached by the move instructions.
// Assumes the pipeline presents one request per cycle, same clock domain.
//
// Overview of operation
// - After reset scalar and SIMD instructions are undefined until enabled.
// - Operations execute only when enable bit 30 of exception control is 1.
// - Enable clear: only privileged moves to/from exception control and id registers, or from feature registers.
// - Coprocessors ten and eleven need access granted at current privilege.
// - Non-secure state needs both non-secure access bits 11 and 10 set.
// - In non-secure state, hypervisor trap bits for ten and eleven must be zero to allow.
// - SIMD also needs its disable bit clear, and in non-secure state its trap fields clear.
// - Scalar operations run fully in hardware in every rounding mode.
// - Short-vector operations are unsupported and always undefined.
// - A vector trap leaves the vector exception flag unchanged.
// - No asynchronous floating-point exceptions are ever signalled.
// - Builds allowed: SIMD plus float, float only, or neither.
// - Register file holds 32 double-precision registers.
// - Id and feature registers are read through the move instructions.
// - Status and control register is read-write, resets to zero.
// - Exception control register is read-write, resets to zero.
// - Feature registers are read-only constants 0x10110222 and 0x11111111.
`include "fsg_map.svh"

module fsg_gate #(
	parameter bit HAS_FP = 1'b1,
	parameter bit HAS_SIMD = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic issue_valid_i,
	input wire logic [2:0] issue_op_i,
	input wire logic [2:0] issue_sel_i,
	input wire logic [`FSG_DW-1:0] issue_wdata_i,
	input wire logic [1:0] priv_level_i,
	input wire logic nonsecure_i,
	input wire logic [3:0] coproc_access_i,
	input wire logic simd_disable_bit_i,
	input wire logic hyp_trap_coproc_ten_i,
	input wire logic hyp_trap_coproc_eleven_i,
	input wire logic hyp_simd_trap_bit_i,
	input wire logic ns_coproc_ten_i,
	input wire logic ns_coproc_eleven_i,
	input wire logic nonsecure_simd_disable_bit_i,
	output logic exec_o,
	output logic undef_o,
	output logic [`FSG_DW-1:0] rdata_o,
	output logic rdata_valid_o,
	output logic unit_enable_o,
	output logic [`FSG_DW-1:0] fp_status_control_o,
	output logic [1:0] state_o
);

	// -----------------------------------------------------------------------
	// Build check
	// -----------------------------------------------------------------------
	// SIMD without floating point is not a legal build
	localparam bit SIMD_OK = HAS_SIMD && HAS_FP;

	// -----------------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------------
	logic [`FSG_DW-1:0] fp_exception_control_reg;
	logic [`FSG_DW-1:0] fp_status_control_reg;
	fsg_pkg::fsg_state_e state_reg;
	logic exec_reg;
	logic undef_reg;
	logic [`FSG_DW-1:0] rdata_reg;
	logic rdata_valid_reg;

	// -----------------------------------------------------------------------
	// Decode functions
	// -----------------------------------------------------------------------
	// Access field for one coprocessor allows the current privilege level
	function automatic logic cpa_allows(input logic [1:0] fld,
		input logic [1:0] pl);
		logic ok;
		ok = 1'b0;
		if (fld == `FSG_CPA_FULL) begin
			ok = 1'b1;
		end else if (fld == `FSG_CPA_PRIV) begin
			ok = (pl != `FSG_PL_USER);
		end
		return ok;
	endfunction : cpa_allows

	// Read value of a system register selector
	function automatic logic [`FSG_DW-1:0] sysreg_read(input logic [2:0] sel,
		input logic [`FSG_DW-1:0] exc, input logic [`FSG_DW-1:0] scr);
		logic [`FSG_DW-1:0] v;
		v = `FSG_ZERO_WORD;
		if (sel == `FSG_SEL_SYSID) begin
			v = `FSG_SYSID_VAL;
		end else if (sel == `FSG_SEL_FP_STATUS_CONTROL_REG) begin
			v = scr;
		end else if (sel == `FSG_SEL_FP_EXCEPTION_CONTROL_REG) begin
			v = exc;
		end else if (sel == `FSG_SEL_MFA) begin
			v = `FSG_MFA_VAL;
		end else if (sel == `FSG_SEL_MFB) begin
			v = `FSG_MFB_VAL;
		end
		return v;
	endfunction : sysreg_read

	// -----------------------------------------------------------------------
	// Permit decision
	// -----------------------------------------------------------------------
	logic en_bit;
	logic privileged;
	logic cp_ok;
	logic ns_ok;
	logic hyp_ok;
	logic simd_ok;
	logic is_move;
	logic move_exempt;
	logic present;
	logic permit;

	always_comb begin
		en_bit = fp_exception_control_reg[`FSG_EN_BIT];
		privileged = (priv_level_i != `FSG_PL_USER);
		// Both fields are checked; differing fields are software's fault
		cp_ok = cpa_allows(coproc_access_i[1:0], priv_level_i) &&
			cpa_allows(coproc_access_i[3:2], priv_level_i);
		ns_ok = !nonsecure_i ||
			(ns_coproc_ten_i && ns_coproc_eleven_i);
		hyp_ok = !nonsecure_i ||
			(!hyp_trap_coproc_ten_i && !hyp_trap_coproc_eleven_i);
		simd_ok = SIMD_OK && !simd_disable_bit_i &&
			!(nonsecure_i && nonsecure_simd_disable_bit_i) &&
			!(nonsecure_i && hyp_simd_trap_bit_i);
		is_move = (issue_op_i == fsg_pkg::FSG_OP_MOVE_TO) ||
			(issue_op_i == fsg_pkg::FSG_OP_MOVE_FROM);
		move_exempt = 1'b0;
		if (privileged && issue_op_i == fsg_pkg::FSG_OP_MOVE_TO) begin
			move_exempt = (issue_sel_i == `FSG_SEL_FP_EXCEPTION_CONTROL_REG) ||
				(issue_sel_i == `FSG_SEL_SYSID);
		end else if (privileged &&
			issue_op_i == fsg_pkg::FSG_OP_MOVE_FROM) begin
			move_exempt = (issue_sel_i == `FSG_SEL_FP_EXCEPTION_CONTROL_REG) ||
				(issue_sel_i == `FSG_SEL_SYSID) ||
				(issue_sel_i == `FSG_SEL_MFA) ||
				(issue_sel_i == `FSG_SEL_MFB);
		end
		present = HAS_FP;
		if (issue_op_i == fsg_pkg::FSG_OP_SIMD) begin
			present = SIMD_OK && simd_ok;
		end
		permit = present && cp_ok && ns_ok && hyp_ok &&
			(en_bit || (is_move && move_exempt));
		// Short vectors never execute
		if (issue_op_i == fsg_pkg::FSG_OP_VECTOR) begin
			permit = 1'b0;
		end
		if (issue_op_i > fsg_pkg::FSG_OP_MOVE_FROM) begin
			permit = 1'b0;
		end
	end

	// -----------------------------------------------------------------------
	// Exception control register
	// -----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			fp_exception_control_reg <= `FSG_FP_EXCEPTION_CONTROL_REG_RST;
		end else if (issue_valid_i && permit &&
			issue_op_i == fsg_pkg::FSG_OP_MOVE_TO &&
			issue_sel_i == `FSG_SEL_FP_EXCEPTION_CONTROL_REG) begin
			fp_exception_control_reg <= issue_wdata_i;
		end
		// Vector traps never touch the flag: no other write path exists
	end

	// -----------------------------------------------------------------------
	// Status and control register
	// -----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			fp_status_control_reg <= `FSG_FP_STATUS_CONTROL_REG_RST;
		end else if (issue_valid_i && permit &&
			issue_op_i == fsg_pkg::FSG_OP_MOVE_TO &&
			issue_sel_i == `FSG_SEL_FP_STATUS_CONTROL_REG) begin
			fp_status_control_reg <= issue_wdata_i;
		end
	end

	// -----------------------------------------------------------------------
	// Issue outcome, registered one cycle after the instruction
	// -----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			exec_reg <= 1'b0;
			undef_reg <= 1'b0;
			state_reg <= fsg_pkg::FSG_ST_IDLE;
		end else if (issue_valid_i) begin
			// Scalar ops need no support code; outcome is per instruction
			exec_reg <= permit;
			undef_reg <= !permit;
			state_reg <= permit ? fsg_pkg::FSG_ST_EXEC :
				fsg_pkg::FSG_ST_UNDEF;
		end else begin
			exec_reg <= 1'b0;
			undef_reg <= 1'b0;
			state_reg <= fsg_pkg::FSG_ST_IDLE;
		end
	end

	// -----------------------------------------------------------------------
	// Move-from read data
	// -----------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rdata_reg <= `FSG_ZERO_WORD;
			rdata_valid_reg <= 1'b0;
		end else if (issue_valid_i && permit &&
			issue_op_i == fsg_pkg::FSG_OP_MOVE_FROM) begin
			rdata_reg <= sysreg_read(issue_sel_i, fp_exception_control_reg,
				fp_status_control_reg);
			rdata_valid_reg <= 1'b1;
		end else begin
			rdata_valid_reg <= 1'b0;
		end
	end

	assign exec_o = exec_reg;
	assign undef_o = undef_reg;
	assign rdata_o = rdata_reg;
	assign rdata_valid_o = rdata_valid_reg;
	assign unit_enable_o = fp_exception_control_reg[`FSG_EN_BIT];
	assign fp_status_control_o = fp_status_control_reg;
	assign state_o = state_reg;

endmodule : fsg_gate

// *** sim/fsg_cpu_model.sv ***
// Processor-side model: turns the three access control words into the
// gate's control lines. Assumes the words stay stable while requests issue.
module fsg_cpu_model (
	input wire logic [31:0] access_word_i,
	input wire logic [31:0] ns_word_i,
	input wire logic [31:0] trap_word_i,
	output logic [3:0] coproc_access_o,
	output logic simd_disable_bit_o,
	output logic ns_ten_o,
	output logic ns_eleven_o,
	output logic ns_simd_dis_o,
	output logic trap_ten_o,
	output logic trap_eleven_o,
	output logic trap_simd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// Field decode
	// ---------------------------------------------------------------
	assign coproc_access_o = access_word_i[23:20];
	assign simd_disable_bit_o = access_word_i[31];
	assign ns_ten_o = ns_word_i[10];
	assign ns_eleven_o = ns_word_i[11];
	assign ns_simd_dis_o = |ns_word_i[15:14];
	assign trap_ten_o = trap_word_i[10];
	assign trap_eleven_o = trap_word_i[11];
	assign trap_simd_o = |trap_word_i[15:14];
endmodule : fsg_cpu_model

// *** sim/fsg_gate_properties.sv ***
// Checker on the gate's issue answers, bound into every fsg_gate.
// Assumes one clock and a synchronous active-high reset.
`include "fsg_map.svh"
module fsg_chk (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic issue_valid_i,
	input wire logic [2:0] issue_op_i,
	input wire logic [2:0] issue_sel_i,
	input wire logic [`FSG_DW-1:0] issue_wdata_i,
	input wire logic [1:0] priv_level_i,
	input wire logic nonsecure_i,
	input wire logic [3:0] coproc_access_i,
	input wire logic simd_disable_bit_i,
	input wire logic hyp_trap_coproc_ten_i,
	input wire logic hyp_trap_coproc_eleven_i,
	input wire logic ns_coproc_ten_i,
	input wire logic ns_coproc_eleven_i,
	input wire logic exec_o,
	input wire logic undef_o,
	input wire logic [`FSG_DW-1:0] rdata_o,
	input wire logic rdata_valid_o,
	input wire logic unit_enable_o,
	input wire logic [`FSG_DW-1:0] fp_status_control_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// Issue outcome properties
	// ---------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	one_answer_a: assert property (
		issue_valid_i |=> exec_o ^ undef_o)
		else $error("request not answered by exactly one outcome");
	no_spurious_a: assert property (
		!issue_valid_i |=> !exec_o && !undef_o)
		else $error("outcome without a request");
	vector_refused_a: assert property (
		issue_valid_i && issue_op_i == fsg_pkg::FSG_OP_VECTOR |=> undef_o)
		else $error("short-vector op not refused");
	disabled_trap_a: assert property (
		issue_valid_i && !unit_enable_o &&
		(issue_op_i < 3'h3 || priv_level_i == `FSG_PL_USER) |=> undef_o)
		else $error("op ran while unit disabled");
	access_gate_a: assert property (
		issue_valid_i && coproc_access_i == 4'h0 |=> undef_o)
		else $error("op ran without coprocessor access");
	ns_gate_a: assert property (
		issue_valid_i && nonsecure_i &&
		!(ns_coproc_ten_i && ns_coproc_eleven_i) |=> undef_o)
		else $error("non-secure op ran without access bits");
	hyp_trap_a: assert property (
		issue_valid_i && nonsecure_i &&
		(hyp_trap_coproc_ten_i || hyp_trap_coproc_eleven_i) |=> undef_o)
		else $error("op ran with hypervisor trap set");
	simd_gate_a: assert property (
		issue_valid_i && issue_op_i == fsg_pkg::FSG_OP_SIMD &&
		simd_disable_bit_i |=> undef_o)
		else $error("SIMD op ran while disabled");
	feature_read_a: assert property (
		issue_valid_i && issue_op_i == fsg_pkg::FSG_OP_MOVE_FROM &&
		issue_sel_i == `FSG_SEL_MFA ##1 exec_o |->
		rdata_valid_o && rdata_o == `FSG_MFA_VAL)
		else $error("feature word wrong");
	enable_write_a: assert property (
		issue_valid_i && issue_op_i == fsg_pkg::FSG_OP_MOVE_TO &&
		issue_sel_i == `FSG_SEL_FP_EXCEPTION_CONTROL_REG ##1 exec_o |->
		unit_enable_o == $past(issue_wdata_i[`FSG_EN_BIT]))
		else $error("enable bit not written");
	reset_clear_a: assert property (
		$fell(sys_rst_i) |->
		!unit_enable_o && fp_status_control_o == `FSG_ZERO_WORD)
		else $error("registers not cleared by reset");
endmodule : fsg_chk
bind fsg_gate fsg_chk chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
	.issue_valid_i(issue_valid_i), .issue_op_i(issue_op_i),
	.issue_sel_i(issue_sel_i), .issue_wdata_i(issue_wdata_i),
	.priv_level_i(priv_level_i), .nonsecure_i(nonsecure_i),
	.coproc_access_i(coproc_access_i), .simd_disable_bit_i(simd_disable_bit_i),
	.hyp_trap_coproc_ten_i(hyp_trap_coproc_ten_i),
	.hyp_trap_coproc_eleven_i(hyp_trap_coproc_eleven_i),
	.ns_coproc_ten_i(ns_coproc_ten_i), .ns_coproc_eleven_i(ns_coproc_eleven_i),
	.exec_o(exec_o), .undef_o(undef_o), .rdata_o(rdata_o),
	.rdata_valid_o(rdata_valid_o), .unit_enable_o(unit_enable_o),
	.fp_status_control_o(fp_status_control_o));

// *** sim/testbench.sv ***
// Self-checking bench for fsg_gate beside the processor-side model.
// Assumes the design files and fsg_map.svh are compiled first.
`include "fsg_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [2:0] op;
		logic [1:0] pl;
		logic ns;
		logic [31:0] ca, na, hc;
		logic ex;
	} fsg_row_s;
	localparam logic [31:0] F = 32'h00f0_0000;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic v = 1'b0;
	logic ns = 1'b0;
	logic [2:0] op = 3'h0, sel = 3'h0;
	logic [1:0] pl = 2'h1;
	logic [31:0] wd = 32'h0, ca = 32'h0, na = 32'h0, hc = 32'h0;
	logic [3:0] acc;
	logic sd, nt, ne, nsd, tt, te, tsd, ex, ud, rv, en;
	logic [31:0] rd, scr;
	logic [1:0] st;
	fsg_row_s r;
	int n_fail = 0, check_count = 0;
	fsg_row_s rows[0:11] = '{
		'{3'h0, 2'h1, 1'h0, F, 32'h0, 32'h0, 1'h1},
		'{3'h1, 2'h1, 1'h0, F, 32'h0, 32'h0, 1'h1},
		'{3'h2, 2'h1, 1'h0, F, 32'h0, 32'h0, 1'h0},
		'{3'h0, 2'h1, 1'h0, 32'h0, 32'h0, 32'h0, 1'h0},
		'{3'h0, 2'h0, 1'h0, 32'h0050_0000, 32'h0, 32'h0, 1'h0},
		'{3'h0, 2'h1, 1'h0, 32'h0050_0000, 32'h0, 32'h0, 1'h1},
		'{3'h0, 2'h1, 1'h1, F, 32'h0400, 32'h0, 1'h0},
		'{3'h0, 2'h1, 1'h1, F, 32'h0c00, 32'h0, 1'h1},
		'{3'h0, 2'h2, 1'h1, F, 32'h0c00, 32'h0800, 1'h0},
		'{3'h1, 2'h1, 1'h0, 32'h80f0_0000, 32'h0, 32'h0, 1'h0},
		'{3'h1, 2'h1, 1'h1, F, 32'hcc00, 32'h0, 1'h0},
		'{3'h1, 2'h2, 1'h1, F, 32'h0c00, 32'hc000, 1'h0}
	};
	always #25 clk_sys = ~clk_sys;
	fsg_cpu_model cpu (.access_word_i(ca), .ns_word_i(na), .trap_word_i(hc),
		.coproc_access_o(acc), .simd_disable_bit_o(sd), .ns_ten_o(nt),
		.ns_eleven_o(ne), .ns_simd_dis_o(nsd), .trap_ten_o(tt),
		.trap_eleven_o(te), .trap_simd_o(tsd));
	fsg_gate dut (.clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .issue_valid_i(v),
		.issue_op_i(op), .issue_sel_i(sel), .issue_wdata_i(wd),
		.priv_level_i(pl), .nonsecure_i(ns), .coproc_access_i(acc),
		.simd_disable_bit_i(sd), .hyp_trap_coproc_ten_i(tt),
		.hyp_trap_coproc_eleven_i(te), .hyp_simd_trap_bit_i(tsd),
		.ns_coproc_ten_i(nt), .ns_coproc_eleven_i(ne),
		.nonsecure_simd_disable_bit_i(nsd), .exec_o(ex), .undef_o(ud),
		.rdata_o(rd), .rdata_valid_o(rv), .unit_enable_o(en),
		.fp_status_control_o(scr), .state_o(st));
	// ---------------------------------------------------------------
	// Tasks and sequence
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic go(input logic [2:0] o, input logic [2:0] s,
		input logic [31:0] w, input logic e);
		@(posedge clk_sys);
		v <= 1'b1;
		op <= o;
		sel <= s;
		wd <= w;
		pl <= r.pl;
		ns <= r.ns;
		ca <= r.ca;
		na <= r.na;
		hc <= r.hc;
		@(posedge clk_sys);
		v <= 1'b0;
		#1;
		chk({31'h0, e}, {31'h0, ex});
		chk({31'h0, !e}, {31'h0, ud});
		chk({30'h0, e ? 2'h1 : 2'h2}, {30'h0, st});
		chk({31'h0, e && o == 3'h4}, {31'h0, rv});
	endtask : go
	task automatic give_verdict;
		$display("Checks %0d, errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		n_fail++;
		give_verdict();
	end
	initial begin
		r = rows[0];
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		chk(32'h0, {31'h0, en});
		go(3'h0, 3'h0, 32'h0, 1'b0);
		go(3'h4, `FSG_SEL_MFA, 32'h0, 1'b1);
		chk(`FSG_MFA_VAL, rd);
		go(3'h4, `FSG_SEL_MFB, 32'h0, 1'b1);
		chk(`FSG_MFB_VAL, rd);
		go(3'h4, `FSG_SEL_SYSID, 32'h0, 1'b1);
		chk(`FSG_SYSID_VAL, rd);
		go(3'h3, `FSG_SEL_FP_STATUS_CONTROL_REG, 32'h0000_00a5, 1'b0);
		chk(`FSG_FP_STATUS_CONTROL_REG_RST, scr);
		r.pl = 2'h0;
		go(3'h4, `FSG_SEL_FP_EXCEPTION_CONTROL_REG, 32'h0, 1'b0);
		r.pl = 2'h1;
		go(3'h3, `FSG_SEL_FP_EXCEPTION_CONTROL_REG, 32'h4000_0000, 1'b1);
		chk(32'h1, {31'h0, en});
		foreach (rows[i]) begin
			r = rows[i];
			go(r.op, 3'h0, 32'h0, r.ex);
		end
		r = rows[0];
		go(3'h3, `FSG_SEL_FP_STATUS_CONTROL_REG, 32'h0c00_0000, 1'b1);
		chk(32'h0c00_0000, scr);
		go(3'h2, 3'h0, 32'h0, 1'b0);
		go(3'h4, `FSG_SEL_FP_EXCEPTION_CONTROL_REG, 32'h0, 1'b1);
		chk(32'h4000_0000, rd);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		chk(32'h0, {31'h0, en});
		chk(`FSG_FP_STATUS_CONTROL_REG_RST, scr);
		go(3'h0, 3'h0, 32'h0, 1'b0);
		give_verdict();
	end
endmodule : testbench
